// *** logic/psl_defines.svh ***
/*
  strap and indicator constants for the strap/indicator block.
  assumes inclusion by bare name from the design file.
*/
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH
`define PSL_ADDR_BIT0        0
`define PSL_SPEED_BIT        13
`define PSL_DUPLEX_BIT       8
`define PSL_ANEG_BIT         12
`define PSL_INT_POL_BIT      9
`define PSL_LED_ALL_OFF      5'h1f
`define PSL_ACT_TOGGLE_NS    50000000
`define PSL_CLK_NS           50
`define PSL_ACT_TOGGLE_CYC   (`PSL_ACT_TOGGLE_NS / `PSL_CLK_NS)
`endif

// *** logic/psl_pkg.sv ***
/*
  types for the strap/indicator block.
  uses nothing from psl_defines.svh.
*/
package psl_pkg;
  typedef struct packed {
    logic rmii_sel;
    logic back_to_back;
    logic addr0;
    logic test_mode;
    logic speed_100;
    logic full_duplex;
    logic autoneg_enable_bit;
  } psl_strap_t;
  typedef struct packed {
    logic link_up;
    logic activity;
    logic speed_100;
    logic full_duplex;
    logic collision;
    logic irq;
  } psl_status_t;
endpackage

// *** logic/psl_strap_led.sv ***
/*
  strap capture during reset and indicator drive afterwards, active-low except the interrupt, whose polarity int_polarity_high sets.
  assumes one 20 MHz clock, synchronous pins, board pull resistors on pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_defines.svh"
module psl_strap_led
  import psl_pkg::*;
#(
  parameter int ACT_TOGGLE_CYC = `PSL_ACT_TOGGLE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire psl_status_t status,
  input  wire logic        int_polarity_high,
  input  wire logic        col_pin_i,
  output logic             col_pin_o,
  output logic             col_pin_oe,
  input  wire logic        carrier_back_to_back_strap_i,
  output logic             carrier_back_to_back_strap_oe,
  input  wire logic        interrupt_addr0_pin_i,
  output logic             interrupt_addr0_pin_o,
  output logic             interrupt_addr0_pin_oe,
  input  wire logic        link_activity_test_pin_i,
  output logic             link_activity_test_pin_o,
  output logic             link_activity_test_pin_oe,
  input  wire logic        speed_pin_i,
  output logic             speed_pin_o,
  output logic             speed_pin_oe,
  input  wire logic        duplex_pin_i,
  output logic             duplex_pin_o,
  output logic             duplex_pin_oe,
  output psl_strap_t       straps,
  output logic             effective_back_to_back
);
  // strap group: pin levels taken on every reset edge, frozen afterwards
  psl_strap_t  strap_reg;
  psl_strap_t  strap_next;
  // run group: low while the shared pins are released
  logic        run_reg;
  logic        run_next;
  // blink group: activity divider and blink phase
  logic        blink_reg;
  logic        blink_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        act_tick;
  // indicator group: link, speed, duplex, collision, interrupt from bit 0 up
  logic [4:0]  out_reg;
  logic [4:0]  out_next;

  always_comb begin
    strap_next = strap_reg;
    // all default straps, autoneg included
    // the last reset edge wins, so slow pull-ups settle before the value counts
    if (!rst_b) begin
      strap_next.rmii_sel           = col_pin_i;
      strap_next.back_to_back       = carrier_back_to_back_strap_i;
      strap_next.addr0              = interrupt_addr0_pin_i;
      strap_next.test_mode          = ~link_activity_test_pin_i;
      strap_next.speed_100          = speed_pin_i;
      strap_next.full_duplex        = duplex_pin_i;
      // same pin as the reduced MII select: the two defaults cannot differ
      strap_next.autoneg_enable_bit = col_pin_i;
    end
  end

  always_ff @(posedge mclk) begin
    strap_reg <= strap_next;
  end

  always_comb begin
    run_next = rst_b;
  end

  always_ff @(posedge mclk) begin
    run_reg <= run_next;
  end

  // one-cycle enable that paces the activity blink
  assign act_tick = (cnt_reg >= 32'(ACT_TOGGLE_CYC - 1));

  always_comb begin
    cnt_next   = 32'h0;
    blink_next = 1'b0;
    // toggle during activity
    // phase restarts when activity stops, so a new burst always starts lit
    if (rst_b && status.activity && status.link_up) begin
      if (act_tick) begin
        blink_next = ~blink_reg;
      end else begin
        cnt_next   = cnt_reg + 32'h1;
        blink_next = blink_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    blink_reg <= blink_next;
    cnt_reg   <= cnt_next;
  end

  always_comb begin
    // all indicator bits high in reset; the pins are released then anyway
    out_next = `PSL_LED_ALL_OFF;
    if (rst_b) begin
      // low on link, toggle on activity
      out_next[0] = ~status.link_up | blink_reg;
      // high at 10, low at 100
      out_next[1] = ~status.speed_100;
      out_next[2] = ~status.full_duplex;
      out_next[3] = ~status.collision;
      out_next[4] = int_polarity_high ? status.irq : ~status.irq;
    end
  end

  always_ff @(posedge mclk) begin
    out_reg <= out_next;
  end

  assign col_pin_oe                    = run_reg;
  assign link_activity_test_pin_oe     = run_reg;
  assign speed_pin_oe                  = run_reg;
  assign duplex_pin_oe                 = run_reg;
  assign interrupt_addr0_pin_oe        = run_reg;
  // carrier pin is MII data path here, never driven by this block
  assign carrier_back_to_back_strap_oe = 1'b0;
  assign link_activity_test_pin_o      = out_reg[0];
  assign speed_pin_o                   = out_reg[1];
  assign duplex_pin_o                  = out_reg[2];
  assign col_pin_o                     = out_reg[3];
  assign interrupt_addr0_pin_o         = out_reg[4];
  assign straps                        = strap_reg;
  assign effective_back_to_back        = strap_reg.back_to_back & strap_reg.rmii_sel;

  strap_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> straps == $past(straps))
    else $error("strap changed");
  rmii_capture_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |-> straps.rmii_sel == $past(col_pin_i))
    else $error("rmii strap");
  btb_capture_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |-> straps.back_to_back == $past(carrier_back_to_back_strap_i))
    else $error("back-to-back strap");
  addr_capture_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |-> straps.addr0 == $past(interrupt_addr0_pin_i))
    else $error("addr");
  speed_capture_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |-> straps.speed_100 == $past(speed_pin_i))
    else $error("speed strap");
  duplex_capture_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |-> straps.full_duplex == $past(duplex_pin_i))
    else $error("duplex strap");
  autoneg_capture_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |-> straps.autoneg_enable_bit == $past(col_pin_i))
    else $error("autoneg strap");
  pins_released_a: assert property (@(posedge mclk)
    !rst_b ##1 1 |-> !speed_pin_oe && !col_pin_oe && !duplex_pin_oe &&
    !link_activity_test_pin_oe && !interrupt_addr0_pin_oe)
    else $error("pin driven in reset");
  pins_driven_a: assert property (@(posedge mclk)
    !rst_b ##1 rst_b |=> speed_pin_oe && col_pin_oe && duplex_pin_oe &&
    link_activity_test_pin_oe && interrupt_addr0_pin_oe)
    else $error("pin not driven");
  speed_led_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> speed_pin_o == !$past(status.speed_100))
    else $error("speed led");
  duplex_led_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> duplex_pin_o == !$past(status.full_duplex))
    else $error("duplex led");
  col_led_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> col_pin_o == !$past(status.collision))
    else $error("col led");
  irq_pol_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> interrupt_addr0_pin_o ==
    ($past(int_polarity_high) ? $past(status.irq) : !$past(status.irq)))
    else $error("irq");
  link_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) && !$past(status.link_up) |-> link_activity_test_pin_o)
    else $error("link");
  link_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) && $past(status.link_up) && !$past(status.activity, 2)
    |-> !link_activity_test_pin_o)
    else $error("link on");
  btb_gate_a: assert property (@(posedge mclk)
    !straps.rmii_sel |-> !effective_back_to_back)
    else $error("btb");

  blink_c: cover property (@(posedge mclk) disable iff (!rst_b) $rose(blink_reg));
  rmii_c: cover property (@(posedge mclk) rst_b && straps.rmii_sel);
  irq_c: cover property (@(posedge mclk) disable iff (!rst_b) status.irq && !int_polarity_high);
  release_c: cover property (@(posedge mclk) !rst_b ##1 rst_b);
  btb_on_c: cover property (@(posedge mclk) rst_b && effective_back_to_back);
endmodule
`default_nettype wire

// *** sim/psl_board.sv ***
/*
  board model: strap pull resistors and indicator loads on shared pins.
  assumes oe high while the block drives; bits col,int,link,speed,duplex,crs.
*/
`timescale 1ns/1ps
`default_nettype none
module psl_board (
  input  wire logic [5:0] pull,
  input  wire logic [4:0] oe,
  input  wire logic [4:0] drv,
  output logic      [5:0] pin
);
  // link pull high
  // no pull-down on the link pin: a low would enter factory test mode
  assign pin = {pull[5], (oe & drv) | (~oe & (pull[4:0] | 5'h04))};
endmodule
`default_nettype wire

// *** sim/psl_strap_led_tb.sv ***
/*
  self-checking bench for the strap/indicator block.
  assumes psl_board as the far side and a short blink count of 4.
*/
`timescale 1ns/1ps
`default_nettype none
module psl_strap_led_tb;
  import psl_pkg::*;
  logic        mclk = 0, rst_b = 0, pol = 1, ebb;
  psl_status_t status = '0;
  psl_strap_t  straps;
  logic [5:0]  pull = 6'h3f, pin;
  logic [4:0]  oe, drv;
  logic        crs_oe;
  int          bad_count = 0, samples_checked = 0;
  always #25 mclk = ~mclk;
  psl_board i_psl_board (.pull(pull), .oe(oe), .drv(drv), .pin(pin));
  psl_strap_led #(.ACT_TOGGLE_CYC(4)) i_psl_strap_led (
    .mclk(mclk), .rst_b(rst_b), .status(status), .int_polarity_high(pol),
    .col_pin_i(pin[0]), .col_pin_o(drv[0]), .col_pin_oe(oe[0]),
    .carrier_back_to_back_strap_i(pin[5]), .carrier_back_to_back_strap_oe(crs_oe),
    .interrupt_addr0_pin_i(pin[1]), .interrupt_addr0_pin_o(drv[1]),
    .interrupt_addr0_pin_oe(oe[1]), .link_activity_test_pin_i(pin[2]),
    .link_activity_test_pin_o(drv[2]), .link_activity_test_pin_oe(oe[2]),
    .speed_pin_i(pin[3]), .speed_pin_o(drv[3]), .speed_pin_oe(oe[3]),
    .duplex_pin_i(pin[4]), .duplex_pin_o(drv[4]), .duplex_pin_oe(oe[4]),
    .straps(straps), .effective_back_to_back(ebb));
  task automatic check(input string what, input logic [6:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic strap_run(input logic [5:0] p);
    @(posedge mclk) #5;
    rst_b = 0;
    pull = p;
    repeat (10) @(posedge mclk);
    #5 check("oe in reset", {1'b0, crs_oe, oe}, 7'h00);
    rst_b = 1;
    @(posedge mclk) #5;
    check("straps", straps, {p[0], p[5], p[1], ~p[2], p[3], p[4], p[0]});
    check("btb", {6'h0, ebb}, {6'h0, p[5] & p[0]});
    pull = ~p | 6'h04;
    repeat (3) @(posedge mclk);
    #5 check("straps held", straps, {p[0], p[5], p[1], ~p[2], p[3], p[4], p[0]});
  endtask
  task automatic led_run(input logic [1:0] i);
    @(posedge mclk) #5;
    status = {1'b1, 1'b0, i[1], ~i[0], i[1], i[0]};
    pol = i[1];
    repeat (2) @(posedge mclk);
    #5 check("oe after reset", {1'b0, crs_oe, oe}, 7'h1f);
    check("pins", {2'h0, pin[4:0]}, {2'h0, i[0], ~i[1], 1'b0, ~(i[0] ^ i[1]), ~i[1]});
  endtask
  task automatic act_run;
    int n;
    logic last;
    n = 0;
    @(posedge mclk) #5;
    status = 6'h30;
    @(posedge mclk) #5;
    last = pin[2];
    for (int k = 0; k < 20; k++) begin
      @(posedge mclk) #5;
      if (pin[2] !== last) n++;
      last = pin[2];
    end
    check("blink toggles", 7'(n), 7'h05);
    status = 6'h00;
    repeat (2) @(posedge mclk);
    #5 check("no link off", {6'h0, pin[2]}, 7'h01);
  endtask
  initial begin
    logic [5:0] pats [4] = '{6'h3f, 6'h04, 6'h25, 6'h24};
    foreach (pats[j]) strap_run(pats[j]);
    for (int i = 0; i < 4; i++) led_run(i[1:0]);
    act_run();
    conclude();
  end
endmodule
`default_nettype wire
